// ==== logic/twee_pkg.sv ====
package twee_pkg;

    // sampled levels of the two serial lines
    typedef struct packed {
        logic scl;
        logic sda;
    } twee_bus_t;

    // one-hot protocol states
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_DEV  = 7'h02,
        S_AHI  = 7'h04,
        S_ALO  = 7'h08,
        S_WR   = 7'h10,
        S_RD   = 7'h20,
        S_PROG = 7'h40
    } twee_state_t;

    // device address word layout
    localparam logic [3:0] TYPE_ID = 4'ha;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 1;
    localparam int RW_BIT = 0;

    // array organisation
    localparam int ADDR_W = 13;
    localparam int ADDR_W_SMALL = 12;
    localparam int PAGE_W = 5;
    localparam int PAGE_BYTES = 32;
    localparam int MEM_BYTES = 8192;
    localparam logic [12:0] MASK_SMALL = 13'h0fff;
    localparam logic [12:0] MASK_LARGE = 13'h1fff;

    // bit counter values
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    // self-timed program cycle
    localparam int MCLK_PERIOD_NS = 25;
    localparam int PROG_TIME_NS = 5000000;
    localparam int PROG_CYCLES = PROG_TIME_NS / MCLK_PERIOD_NS;
    localparam int TIMER_W = 18;

endpackage : twee_pkg

// ==== logic/twee_target.sv ====
`timescale 1ns/10ps

module twee_target
    import twee_pkg::*;
#(
    parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
)
(
    input wire logic i_mclk, // system clock, 40 MHz
    input wire logic i_sys_rst, // async reset, power-up
    input wire logic i_scl, // serial clock level
    input wire logic i_sda, // serial data line level
    output logic o_sda_out, // serial data drive value, always low
    output logic o_sda_oe, // high while pulling sda low
    input wire logic [2:0] i_chip_select_straps, // strap levels for bits 3..1
    input wire logic i_wp, // write protect, high blocks writes
    input wire logic i_large_array, // high selects the 8192-byte variant
    output logic o_standby, // idle and waiting for start
    output logic o_prog_busy // self-timed program cycle running
);

    ////////////////////////////////////////////////////////////////////////
    // line sampling and condition detection

    twee_bus_t bus_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            bus_q <= '{scl: 1'b1, sda: 1'b1};
        end
        else
        begin
            bus_q <= '{scl: i_scl, sda: i_sda};
        end
    end

    assign scl_rise = i_scl & ~bus_q.scl;
    assign scl_fall = ~i_scl & bus_q.scl;
    // an sda edge while scl stays high is never data
    assign start_det = i_scl & bus_q.scl & bus_q.sda & ~i_sda;
    assign stop_det = i_scl & bus_q.scl & ~bus_q.sda & i_sda;

    ////////////////////////////////////////////////////////////////////////
    // shared state

    twee_state_t state_q;
    twee_state_t nst_q;
    logic [3:0] cnt_q;
    logic nine_q;
    logic ack_q;
    logic oe_q;
    logic [7:0] sh_q;
    logic [7:0] hi_q;
    logic [12:0] addr_q;
    logic [TIMER_W-1:0] timer_q;
    logic [5:0] wr_idx_q;
    logic [12:0] amask;
    logic [7:0] rx_byte;
    logic [7:0] mem_rd;
    logic dev_match;
    logic byte_in;
    logic pb_we;
    logic go_prog;
    logic prog_done;
    logic pb_clr;
    logic [7:0] pb_page_q;
    logic [PAGE_BYTES-1:0] pb_valid_q;
    logic [7:0] pb_data_q [PAGE_BYTES];
    logic [7:0] mem [MEM_BYTES];

    // upper address bits beyond the variant's width are dropped
    assign amask = i_large_array ? MASK_LARGE : MASK_SMALL;
    assign rx_byte = {sh_q[6:0], i_sda};
    assign dev_match = (rx_byte[TYPE_MSB:TYPE_LSB] == TYPE_ID)
        && (rx_byte[SEL_MSB:SEL_LSB] == i_chip_select_straps);
    assign byte_in = scl_rise && (cnt_q == BIT_LAST) && !nine_q;
    assign pb_we = byte_in && (state_q == S_WR);
    // protected writes are acknowledged but never start a program cycle
    assign go_prog = stop_det && (state_q == S_WR) && (|pb_valid_q) && !i_wp;
    assign prog_done = (state_q == S_PROG) && (timer_q == '0);
    assign pb_clr = ((state_q != S_PROG) && (start_det || stop_det) && !go_prog) || prog_done;
    assign mem_rd = mem[addr_q];

    ////////////////////////////////////////////////////////////////////////
    // protocol state machine

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_q <= S_IDLE;
            nst_q <= S_IDLE;
            cnt_q <= 4'h0;
            nine_q <= 1'b0;
            ack_q <= 1'b0;
        end
        else if (state_q == S_PROG)
        begin
            // inputs are ignored, so polls get no acknowledge
            if (prog_done)
            begin
                state_q <= S_IDLE;
            end
        end
        else if (start_det)
        begin
            state_q <= S_DEV;
            cnt_q <= 4'h0;
            nine_q <= 1'b0;
            ack_q <= 1'b0;
        end
        else if (stop_det)
        begin
            state_q <= go_prog ? S_PROG : S_IDLE;
            cnt_q <= 4'h0;
            nine_q <= 1'b0;
            ack_q <= 1'b0;
        end
        else if (state_q != S_IDLE)
        begin
            if (scl_rise)
            begin
                if (cnt_q != BIT_ACK)
                begin
                    cnt_q <= cnt_q + 4'h1;
                end
                else
                begin
                    nine_q <= 1'b1;
                    if (state_q == S_RD)
                    begin
                        // a missing acknowledge ends the read
                        nst_q <= i_sda ? S_IDLE : S_RD;
                    end
                end
                if (byte_in)
                begin
                    case (state_q)
                        S_DEV:
                        begin
                            ack_q <= dev_match;
                            if (!dev_match)
                            begin
                                nst_q <= S_IDLE;
                            end
                            else if (rx_byte[RW_BIT])
                            begin
                                nst_q <= S_RD;
                            end
                            else
                            begin
                                nst_q <= S_AHI;
                            end
                        end
                        S_AHI:
                        begin
                            ack_q <= 1'b1;
                            nst_q <= S_ALO;
                        end
                        S_ALO, S_WR:
                        begin
                            ack_q <= 1'b1;
                            nst_q <= S_WR;
                        end
                        default:
                        begin
                            ack_q <= 1'b0;
                        end
                    endcase
                end
            end
            else if (scl_fall && nine_q)
            begin
                cnt_q <= 4'h0;
                nine_q <= 1'b0;
                state_q <= nst_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sda drive and transmit shifter

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            oe_q <= 1'b0;
            sh_q <= 8'h00;
        end
        else if ((state_q == S_PROG) || start_det || stop_det)
        begin
            oe_q <= 1'b0;
        end
        else if (scl_rise && (cnt_q != BIT_ACK) && (state_q != S_RD))
        begin
            sh_q <= rx_byte;
        end
        else if (scl_fall)
        begin
            // changes only after the falling edge, so never inside scl high
            if (nine_q)
            begin
                if (nst_q == S_RD)
                begin
                    sh_q <= {mem_rd[6:0], 1'b0};
                    oe_q <= ~mem_rd[7];
                end
                else
                begin
                    oe_q <= 1'b0;
                end
            end
            else if (cnt_q == BIT_ACK)
            begin
                oe_q <= ack_q && (state_q != S_RD);
            end
            else if ((state_q == S_RD) && (cnt_q != 4'h0))
            begin
                oe_q <= ~sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
            end
        end
    end

    // open drain: the value is always low, only the enable moves
    assign o_sda_out = 1'b0;
    assign o_sda_oe = oe_q;
    assign o_standby = (state_q == S_IDLE);
    assign o_prog_busy = (state_q == S_PROG);

    ////////////////////////////////////////////////////////////////////////
    // address counter

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            addr_q <= 13'h0000;
            hi_q <= 8'h00;
        end
        else if (byte_in && (state_q == S_AHI))
        begin
            hi_q <= rx_byte;
        end
        else if (byte_in && (state_q == S_ALO))
        begin
            addr_q <= {hi_q[4:0], rx_byte} & amask;
        end
        else if (pb_we)
        begin
            // page row holds, low bits wrap inside the page
            addr_q <= {addr_q[12:PAGE_W], addr_q[PAGE_W-1:0] + 5'h01};
        end
        else if (scl_fall && nine_q && (nst_q == S_RD) && (state_q != S_PROG)
                 && !start_det && !stop_det)
        begin
            // reads wrap from the last byte of the array to zero
            addr_q <= (addr_q + 13'h0001) & amask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // page buffer, committed only by the program cycle

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            pb_page_q <= 8'h00;
        end
        else if (pb_we)
        begin
            pb_page_q <= addr_q[12:PAGE_W];
        end
    end

    generate
        for (genvar gi = 0; gi < PAGE_BYTES; gi++)
        begin : g_pbuf
            always_ff @(posedge i_mclk or posedge i_sys_rst)
            begin
                if (i_sys_rst)
                begin
                    pb_valid_q[gi] <= 1'b0;
                    pb_data_q[gi] <= 8'h00;
                end
                else if (pb_clr)
                begin
                    pb_valid_q[gi] <= 1'b0;
                end
                else if (pb_we && (addr_q[PAGE_W-1:0] == 5'(gi)))
                begin
                    // a later byte to the same slot overwrites the earlier one
                    pb_valid_q[gi] <= 1'b1;
                    pb_data_q[gi] <= rx_byte;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // self-timed program cycle

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            timer_q <= '0;
            wr_idx_q <= 6'h00;
        end
        else if (go_prog)
        begin
            timer_q <= TIMER_W'(PROG_CYCLES_P - 1);
            wr_idx_q <= 6'h00;
        end
        else if (state_q == S_PROG)
        begin
            if (timer_q != '0)
            begin
                timer_q <= timer_q - 1'b1;
            end
            if (!wr_idx_q[5])
            begin
                wr_idx_q <= wr_idx_q + 6'h01;
            end
        end
    end

    // one byte per clock, so the timer must cover at least one page
    always_ff @(posedge i_mclk)
    begin
        if ((state_q == S_PROG) && !wr_idx_q[5] && pb_valid_q[wr_idx_q[4:0]])
        begin
            mem[{pb_page_q, wr_idx_q[4:0]}] <= pb_data_q[wr_idx_q[4:0]];
        end
    end

endmodule : twee_target

// ==== verif/twee_target_assertions.sv ====
`timescale 1ns/10ps
module twee_target_assertions
#(
    parameter int unsigned PROG_CYCLES_P = 40
)
(
    input wire logic i_mclk, // clock
    input wire logic i_sys_rst, // reset
    input wire logic i_scl, // serial clock
    input wire logic i_sda, // data wire
    input wire logic o_sda_out, // drive value
    input wire logic o_sda_oe, // pull enable
    input wire logic [2:0] i_chip_select_straps, // straps
    input wire logic i_wp, // write protect
    input wire logic i_large_array, // variant
    input wire logic o_standby, // idle
    input wire logic o_prog_busy // programming
);
    logic scl_q, sda_q;
    logic [1:0] start_q, stop_q;
    int unsigned cnt_q;
    default clocking dcb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////
    // two deep, the design may react one edge late
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            {scl_q, sda_q, start_q, stop_q} <= 6'h30;
        else
        begin
            {scl_q, sda_q} <= {i_scl, i_sda};
            start_q <= {start_q[0], scl_q & i_scl & sda_q & ~i_sda};
            stop_q <= {stop_q[0], scl_q & i_scl & ~sda_q & i_sda};
        end
    end
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            cnt_q <= 0;
        else
            cnt_q <= o_prog_busy ? cnt_q + 1 : 0;
    end
    ////////////////////////////////////////
    AST_OD_LOW: assert property (o_sda_out == 1'b0)
        else $error("sda drive value not low");
    AST_DEAF: assert property (o_prog_busy |-> !o_sda_oe)
        else $error("sda pulled during program cycle");
    AST_BUSY_NOT_IDLE: assert property (o_prog_busy |-> !o_standby)
        else $error("standby during program cycle");
    AST_OE_ON_LOW: assert property ($rose(o_sda_oe) |-> !$past(i_scl))
        else $error("sda pulled while scl high");
    AST_PROG_LEN: assert property ($fell(o_prog_busy) |->
        $past(cnt_q) == PROG_CYCLES_P - 1 && o_standby) else $error("program length wrong");
    AST_PROG_ON_STOP: assert property ($rose(o_prog_busy) |-> (|stop_q) && !i_wp)
        else $error("program cycle without stop");
    AST_WAKE_ON_START: assert property ($fell(o_standby) |-> |start_q)
        else $error("left standby without start");
    AST_STOP_IDLE: assert property (stop_q[1] |-> o_standby || o_prog_busy)
        else $error("no standby after stop");
    cover property ($rose(o_prog_busy));
    cover property ($rose(o_sda_oe));
    cover property (stop_q[1] && o_standby);
endmodule : twee_target_assertions
bind twee_target twee_target_assertions #(.PROG_CYCLES_P(PROG_CYCLES_P))
    twee_target_assertions_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
    .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_wp(i_wp),
    .i_chip_select_straps(i_chip_select_straps), .i_large_array(i_large_array),
    .o_standby(o_standby), .o_prog_busy(o_prog_busy));

// ==== verif/twee_ctl.sv ====
`timescale 1ns/10ps
module twee_ctl
(
    input wire logic i_mclk, // clock
    input wire logic i_sda, // data wire
    output logic o_scl = 1'b1, // serial clock
    output logic o_sda_oe = 1'b0 // pull sda low
);
    // four samples per level, the design needs two
    task automatic drv(input logic c, input logic o);
        o_scl <= c;
        o_sda_oe <= o;
        repeat (4) @(posedge i_mclk);
    endtask : drv
    task automatic bitx(input logic b, output logic r);
        drv(1'b0, o_sda_oe);
        drv(1'b0, !b);
        drv(1'b1, !b);
        r = i_sda;
    endtask : bitx
    task automatic start();
        drv(1'b0, 1'b0);
        drv(1'b1, 1'b0);
        drv(1'b1, 1'b1);
        drv(1'b0, 1'b1);
    endtask : start
    task automatic stop();
        drv(1'b0, 1'b1);
        drv(1'b1, 1'b1);
        drv(1'b1, 1'b0);
    endtask : stop
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(b[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask : send
    task automatic recv(input logic more, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, v[i]);
        bitx(!more, r);
    endtask : recv
    task automatic recover();
        logic r = 1'b0;
        for (int i = 0; i < 9 && !r; i++)
            bitx(1'b1, r);
        // start while scl is still high: lowering scl first clocks the target once more
        drv(1'b1, 1'b1);
        drv(1'b0, 1'b1);
        stop();
    endtask : recover
endmodule : twee_ctl

// ==== verif/twee_target_tb.sv ====
`timescale 1ns/10ps
module twee_target_tb;
    localparam int unsigned PROG_N = 150;
    logic i_mclk, i_sys_rst = 1'b1, i_wp = 1'b0, i_large_array = 1'b1;
    logic [2:0] straps = 3'h0;
    logic scl, sda, ctl_oe, dut_oe, dut_out, o_standby, o_prog_busy, ack;
    logic [31:0] seed = 32'h33f9;
    logic [7:0] ref_mem [8192];
    logic [7:0] d;
    logic [12:0] a;
    int err_total = 0, num_checks = 0, cyc = 0;
    assign sda = !(ctl_oe || dut_oe);
    twee_target #(.PROG_CYCLES_P(PROG_N)) twee_target_inst (.i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda), .o_sda_out(dut_out),
        .o_sda_oe(dut_oe), .i_chip_select_straps(straps), .i_wp(i_wp),
        .i_large_array(i_large_array), .o_standby(o_standby), .o_prog_busy(o_prog_busy));
    twee_ctl twee_ctl_inst (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda_oe(ctl_oe));
    ////////////////////////////////////////
    initial
    begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            results();
        end
    end
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [12:0] page_adr(input logic [12:0] b, input int i);
        return {b[12:5], b[4:0] + 5'(i)};
    endfunction : page_adr
    // bits above the variant's address width are dropped
    function automatic logic [12:0] in_array(input logic [12:0] x);
        return x & {i_large_array, 12'hfff};
    endfunction : in_array
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    task automatic devw(input logic rw, input logic exp);
        twee_ctl_inst.start();
        twee_ctl_inst.send({4'ha, straps, rw}, ack);
        chk("device ack", ack, exp);
    endtask : devw
    task automatic setaddr(input logic [12:0] adr);
        devw(1'b0, 1'b1);
        twee_ctl_inst.send({3'h0, adr[12:8]}, ack);
        chk("addr hi ack", ack, 1'b1);
        twee_ctl_inst.send(adr[7:0], ack);
        chk("addr lo ack", ack, 1'b1);
    endtask : setaddr
    task automatic wrbytes(input logic [12:0] adr, input int n);
        setaddr(adr);
        for (int i = 0; i < n; i++)
        begin
            seed = lfsr(seed);
            twee_ctl_inst.send(seed[7:0], ack);
            chk("data ack", ack, 1'b1);
            if (!i_wp)
                ref_mem[in_array(page_adr(adr, i))] = seed[7:0];
        end
        twee_ctl_inst.stop();
    endtask : wrbytes
    task automatic rdbytes(input logic [12:0] adr, input int n);
        setaddr(adr);
        devw(1'b1, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            twee_ctl_inst.recv(i < n - 1, d);
            chk("read data", d, ref_mem[in_array(13'(adr + i))]);
        end
        twee_ctl_inst.stop();
    endtask : rdbytes
    task automatic waitprog();
        for (int i = 0; i < 2 * PROG_N && o_prog_busy !== 1'b0; i++)
            @(posedge i_mclk);
        chk("standby after program", o_standby, 1'b1);
    endtask : waitprog
    ////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge i_mclk);
        seed = lfsr(seed);
        i_sys_rst <= 1'b0;
        straps <= seed[2:0];
        repeat (2) @(posedge i_mclk);
        chk("standby", o_standby, 1'b1);
        chk("sda pull", dut_oe, 1'b0);
        chk("sda drive value", dut_out, 1'b0);
        $display("test reset done");
        for (int k = 0; k < 2; k++)
        begin
            twee_ctl_inst.start();
            twee_ctl_inst.send({k ? 4'hb : 4'ha, k ? straps : ~straps, 1'b0}, ack);
            chk("foreign ack", ack, 1'b0);
            twee_ctl_inst.drv(1'b0, 1'b0);
            chk("foreign standby", o_standby, 1'b1);
            twee_ctl_inst.stop();
        end
        $display("test foreign address done");
        seed = lfsr(seed);
        a = seed[12:0];
        wrbytes(a, 1);
        chk("program busy", o_prog_busy, 1'b1);
        devw(1'b0, 1'b0);
        twee_ctl_inst.stop();
        waitprog();
        devw(1'b0, 1'b1);
        twee_ctl_inst.stop();
        rdbytes(a, 1);
        $display("test byte write done");
        i_wp <= 1'b1;
        wrbytes(a, 1);
        chk("protected busy", o_prog_busy, 1'b0);
        i_wp <= 1'b0;
        rdbytes(a, 1);
        $display("test write protect done");
        wrbytes(13'h001e, 34);
        waitprog();
        rdbytes(13'h0000, 32);
        wrbytes(13'h1fff, 1);
        waitprog();
        rdbytes(13'h1fff, 2);
        // smaller variant: the top address bit is ignored, reads wrap at 4096
        i_large_array <= 1'b0;
        wrbytes(13'h1fff, 1);
        waitprog();
        rdbytes(13'h1fff, 2);
        $display("test page and wrap done");
        // counter left one past the last byte read, at address 1
        devw(1'b1, 1'b1);
        twee_ctl_inst.recv(1'b1, d);
        chk("current read", d, ref_mem[13'h0001]);
        twee_ctl_inst.recover();
        chk("standby after recovery", o_standby, 1'b1);
        chk("busy after recovery", o_prog_busy, 1'b0);
        devw(1'b0, 1'b1);
        twee_ctl_inst.stop();
        $display("test recovery done");
        results();
    end
endmodule : twee_target_tb
